// file: wtu_pkg.sv
// Package of constants and types for the wave timer unit.
`default_nettype none
package wtu_pkg;
   localparam int CNT_W = 16;
   localparam int NUM_CH = 3;
   localparam logic [15:0] COUNT_FLOOR = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] COUNT_STEP = 16'h0001;
   localparam logic [15:0] CYCLE_RESET = 16'hFFFF;
   localparam logic [15:0] MATCH_RESET = 16'h0000;
   localparam int PSC_W = 3;
   localparam int DIV_W = 10;
   localparam logic [9:0] DIV_ONE = 10'h001;
   localparam logic [9:0] DIV_ZERO = 10'h000;
   localparam int TOGGLE_CH = 0;
   // Prescale encodings: divide by 1, 2, 4, 8, 16, 64, 256, 1024.
   localparam logic [2:0] PSC_DIV1 = 3'h0;
   localparam logic [2:0] PSC_DIV2 = 3'h1;
   localparam logic [2:0] PSC_DIV4 = 3'h2;
   localparam logic [2:0] PSC_DIV8 = 3'h3;
   localparam logic [2:0] PSC_DIV16 = 3'h4;
   localparam logic [2:0] PSC_DIV64 = 3'h5;
   localparam logic [2:0] PSC_DIV256 = 3'h6;
   localparam logic [2:0] PSC_DIV1024 = 3'h7;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_TOGGLE = 2'h1;
   localparam logic [1:0] MODE_SINGLE = 2'h3;
   typedef enum logic [1:0] {
      WTU_NORMAL,
      WTU_TOGGLE,
      WTU_SINGLE
   } wtu_mode_e;
endpackage : wtu_pkg
`default_nettype wire

// file: wtu_prescaler.sv
// Prescaler that turns the selected division into a one-cycle tick enable.
`default_nettype none
module wtu_prescaler (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Control
   input wire logic run,
   input wire logic [wtu_pkg::PSC_W-1:0] prescale_select,
   // Tick
   output logic tick
);
   logic [wtu_pkg::DIV_W-1:0] div_count;
   logic [wtu_pkg::DIV_W-1:0] div_last;

   always_comb begin
      case (prescale_select)
         wtu_pkg::PSC_DIV1: div_last = 10'h000;
         wtu_pkg::PSC_DIV2: div_last = 10'h001;
         wtu_pkg::PSC_DIV4: div_last = 10'h003;
         wtu_pkg::PSC_DIV8: div_last = 10'h007;
         wtu_pkg::PSC_DIV16: div_last = 10'h00F;
         wtu_pkg::PSC_DIV64: div_last = 10'h03F;
         wtu_pkg::PSC_DIV256: div_last = 10'h0FF;
         default: div_last = 10'h3FF;
      endcase
   end

   // The divider restarts while stopped so the first tick after enabling is a full period.
   always_ff @(posedge ref_clk) begin
      if (reset || !run || div_count >= div_last) begin
         div_count <= wtu_pkg::DIV_ZERO;
      end else begin
         div_count <= div_count + wtu_pkg::DIV_ONE;
      end
   end

   assign tick = run && (div_count >= div_last);
endmodule : wtu_prescaler
`default_nettype wire

// file: wtu_channel.sv
// One compare channel: match flag, double-buffered match value and waveform.
`default_nettype none
module wtu_channel (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Counter state
   input wire logic [wtu_pkg::CNT_W-1:0] count_value,
   input wire logic step,
   input wire logic load_point,
   input wire logic at_ceiling,
   input wire logic [1:0] mode,
   // Software access
   input wire logic match_write,
   input wire logic shadow_write,
   input wire logic [wtu_pkg::CNT_W-1:0] write_data,
   input wire logic flag_clear,
   // State
   output logic [wtu_pkg::CNT_W-1:0] match_value_reg,
   output logic [wtu_pkg::CNT_W-1:0] match_value_shadow,
   output logic match_shadow_valid,
   output logic match_flag,
   output logic wave_out,
   output logic match_now
);
   assign match_now = (count_value == match_value_reg); // [RULE14]

   // Direct writes bypass the shadow; the load point copies a valid shadow.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         match_value_reg <= wtu_pkg::MATCH_RESET;
      end else if (match_write) begin
         match_value_reg <= write_data; // [RULE12]
      end else if (load_point && match_shadow_valid) begin
         match_value_reg <= match_value_shadow; // [RULE11]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         match_value_shadow <= wtu_pkg::MATCH_RESET;
      end else if (shadow_write) begin
         match_value_shadow <= write_data; // [RULE22]
      end
   end

   // A shadow write in the load cycle keeps the flag so the new value is not lost.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         match_shadow_valid <= 1'b0;
      end else if (shadow_write) begin
         match_shadow_valid <= 1'b1; // [RULE10]
      end else if (load_point) begin
         match_shadow_valid <= 1'b0; // [RULE10]
      end
   end

   // Flag is set the cycle after the match; set wins over software clear.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         match_flag <= 1'b0;
      end else if (match_now && step) begin
         match_flag <= 1'b1; // [RULE14]
      end else if (flag_clear) begin
         match_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wave_out <= 1'b0;
      end else if (step) begin
         case (mode)
            wtu_pkg::MODE_TOGGLE: begin
               if (match_now) begin
                  wave_out <= !wave_out; // [RULE17] [RULE18]
               end
            end
            wtu_pkg::MODE_SINGLE: begin
               if (at_ceiling) begin
                  wave_out <= 1'b1; // [RULE19]
               end else if (match_now) begin
                  wave_out <= 1'b0; // [RULE19]
               end
            end
            default: begin
               wave_out <= wave_out;
            end
         endcase
      end
   end
endmodule : wtu_channel
`default_nettype wire

// file: wave_timer_unit.sv
// Sixteen-bit wave timer unit: counter, cycle length buffering and three channels.
//
// Contract
// [RULE1] Floor is zero, ceiling is sequence top.
// [RULE2] Load point at floor or ceiling per mode.
// [RULE3] Software loads cycle length, then sets enable.
// [RULE4] Event count enable counts events, not ticks.
// [RULE5] Count prescaled ticks in the selected direction.
// [RULE6] Upward past ceiling wraps to zero.
// [RULE7] Downward at floor reloads cycle length.
// [RULE8] Count write is immediate and wins.
// [RULE9] Direction changes apply while running.
// [RULE10] Shadow valid set on write, cleared at load.
// [RULE11] Valid shadows copy only at load point.
// [RULE12] Match and shadow registers both directly writable.
// [RULE13] Direct cycle write immediate; overshoot wraps through ones.
// [RULE14] Match sets channel flag one cycle later.
// [RULE15] Waveform drives pin when mode, no events, enabled.
// [RULE16] Software sets pin direction and optional inversion.
// [RULE17] Toggle mode: match toggles output.
// [RULE18] Toggle frequency is clock over twice N(match+1).
// [RULE19] Single slope: set at ceiling, clear on match.
// [RULE20] Resolution follows cycle length, 2 to 16 bits.
// [RULE21] Single slope frequency is clock over N(len+1).
// [RULE22] All counter registers and shadows are 16 bits.
// [RULE23] Toggle mode restarts after channel zero match.
// [RULE24] Prescaler chooses power-of-two dividers.
// [RULE25] Only counts and loads while enabled.
`default_nettype none
module wave_timer_unit (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Control A and E
   input wire logic enable,
   input wire logic [wtu_pkg::PSC_W-1:0] prescale_select,
   input wire logic count_down,
   // Control B
   input wire logic [1:0] wave_mode_select,
   input wire logic [wtu_pkg::NUM_CH-1:0] channel_output_enable,
   // Event control
   input wire logic event_count_enable,
   input wire logic event_in,
   // Software writes
   input wire logic [wtu_pkg::CNT_W-1:0] write_data,
   input wire logic count_write,
   input wire logic cycle_write,
   input wire logic cycle_shadow_write,
   input wire logic [wtu_pkg::NUM_CH-1:0] match_write,
   input wire logic [wtu_pkg::NUM_CH-1:0] match_shadow_write,
   input wire logic [wtu_pkg::NUM_CH-1:0] match_flag_clear,
   input wire logic wrap_flag_clear,
   // Port pin values when not overridden
   input wire logic [wtu_pkg::NUM_CH-1:0] port_out,
   // Register state
   output logic [wtu_pkg::CNT_W-1:0] count_value_reg,
   output logic [wtu_pkg::CNT_W-1:0] cycle_length_reg,
   output logic [wtu_pkg::CNT_W-1:0] cycle_length_shadow,
   output logic cycle_shadow_valid,
   output logic [wtu_pkg::NUM_CH*wtu_pkg::CNT_W-1:0] match_values,
   output logic [wtu_pkg::NUM_CH*wtu_pkg::CNT_W-1:0] match_shadows,
   output logic [wtu_pkg::NUM_CH-1:0] match_shadow_valid,
   // Flags and waveforms
   output logic wrap_flag,
   output logic [wtu_pkg::NUM_CH-1:0] match_flag,
   output logic [wtu_pkg::NUM_CH-1:0] wave_out,
   output logic [wtu_pkg::NUM_CH-1:0] waveform_pin
);
   logic event_meta;
   logic event_sync;
   logic event_prev;
   logic event_edge;
   logic clk_tick;
   logic step;
   logic at_floor;
   logic at_ceiling;
   logic seq_top;
   logic load_point;
   logic wave_mode_on;
   logic down_now;
   logic [wtu_pkg::NUM_CH-1:0] match_now;
   logic [wtu_pkg::CNT_W-1:0] next_count;
   wtu_pkg::wtu_mode_e mode_kind;

   // Event input is asynchronous; two flip-flops before any edge detection.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         event_meta <= 1'b0;
         event_sync <= 1'b0;
      end else begin
         event_meta <= event_in;
         event_sync <= event_meta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         event_prev <= 1'b0;
      end else begin
         event_prev <= event_sync;
      end
   end

   assign event_edge = event_sync && !event_prev;

   wtu_prescaler u_prescaler (
      .ref_clk(ref_clk),
      .reset(reset),
      .run(enable),
      .prescale_select(prescale_select), // [RULE24]
      .tick(clk_tick)
   );

   // Events replace clock ticks as the counting source.
   assign step = enable && (event_count_enable ? event_edge : clk_tick); // [RULE4] [RULE5] [RULE25]

   always_comb begin
      case (wave_mode_select)
         wtu_pkg::MODE_TOGGLE: mode_kind = wtu_pkg::WTU_TOGGLE;
         wtu_pkg::MODE_SINGLE: mode_kind = wtu_pkg::WTU_SINGLE;
         default: mode_kind = wtu_pkg::WTU_NORMAL;
      endcase
   end

   // Single slope always counts up; other modes follow the direction bit live.
   assign down_now = (mode_kind == wtu_pkg::WTU_SINGLE) ? 1'b0 : count_down; // [RULE9]

   // Toggle mode uses channel zero's match as the top of the sequence.
   assign seq_top = (mode_kind == wtu_pkg::WTU_TOGGLE) ? match_now[wtu_pkg::TOGGLE_CH]
                    : (count_value_reg == cycle_length_reg); // [RULE1] [RULE23]
   assign at_floor = (count_value_reg == wtu_pkg::COUNT_FLOOR); // [RULE1]
   assign at_ceiling = seq_top && !down_now;

   // Up-counting loads at the ceiling, down-counting at the floor reload.
   assign load_point = step && (down_now ? at_floor : seq_top); // [RULE2] [RULE25]

   always_comb begin
      if (down_now) begin
         if (at_floor) begin
            next_count = cycle_length_reg; // [RULE7]
         end else begin
            next_count = count_value_reg - wtu_pkg::COUNT_STEP;
         end
      end else if (seq_top) begin
         next_count = wtu_pkg::COUNT_FLOOR; // [RULE6] [RULE23]
      end else begin
         // Past a lowered ceiling the count runs on and wraps at all ones.
         next_count = count_value_reg + wtu_pkg::COUNT_STEP; // [RULE13]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_value_reg <= wtu_pkg::COUNT_FLOOR;
      end else if (count_write) begin
         count_value_reg <= write_data; // [RULE8]
      end else if (step) begin
         count_value_reg <= next_count; // [RULE5]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cycle_length_reg <= wtu_pkg::CYCLE_RESET;
      end else if (cycle_write) begin
         cycle_length_reg <= write_data; // [RULE13]
      end else if (load_point && cycle_shadow_valid) begin
         cycle_length_reg <= cycle_length_shadow; // [RULE11] [RULE20] [RULE21]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cycle_length_shadow <= wtu_pkg::CYCLE_RESET;
      end else if (cycle_shadow_write) begin
         cycle_length_shadow <= write_data; // [RULE22]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cycle_shadow_valid <= 1'b0;
      end else if (cycle_shadow_write) begin
         cycle_shadow_valid <= 1'b1; // [RULE10]
      end else if (load_point) begin
         cycle_shadow_valid <= 1'b0; // [RULE10]
      end
   end

   // Wrap flag marks the ceiling-to-zero or floor reload event.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wrap_flag <= 1'b0;
      end else if (load_point) begin
         wrap_flag <= 1'b1;
      end else if (wrap_flag_clear) begin
         wrap_flag <= 1'b0;
      end
   end

   assign wave_mode_on = (mode_kind != wtu_pkg::WTU_NORMAL) && !event_count_enable;

   genvar ch;
   generate
      for (ch = 0; ch < wtu_pkg::NUM_CH; ch++) begin : g_ch
         wtu_channel u_channel (
            .ref_clk(ref_clk),
            .reset(reset),
            .count_value(count_value_reg),
            .step(step),
            .load_point(load_point),
            .at_ceiling(at_ceiling),
            .mode(wave_mode_select),
            .match_write(match_write[ch]),
            .shadow_write(match_shadow_write[ch]),
            .write_data(write_data),
            .flag_clear(match_flag_clear[ch]),
            .match_value_reg(match_values[ch*wtu_pkg::CNT_W +: wtu_pkg::CNT_W]),
            .match_value_shadow(match_shadows[ch*wtu_pkg::CNT_W +: wtu_pkg::CNT_W]),
            .match_shadow_valid(match_shadow_valid[ch]),
            .match_flag(match_flag[ch]),
            .wave_out(wave_out[ch]),
            .match_now(match_now[ch])
         );
         // Pin direction and inversion live in the port block outside.
         assign waveform_pin[ch] = (wave_mode_on && channel_output_enable[ch])
                                   ? wave_out[ch] : port_out[ch]; // [RULE15] [RULE16]
      end
   endgenerate
endmodule : wave_timer_unit
`default_nettype wire

// file: wtu_assertions.sv
// Port-level checks for the wave timer unit.
`default_nettype none
module wtu_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Controls
   input wire logic enable,
   input wire logic [2:0] prescale_select,
   input wire logic count_down,
   input wire logic [1:0] wave_mode_select,
   input wire logic [2:0] channel_output_enable,
   input wire logic event_count_enable,
   input wire logic [15:0] write_data,
   input wire logic count_write,
   input wire logic cycle_write,
   input wire logic cycle_shadow_write,
   input wire logic [2:0] port_out,
   // State
   input wire logic [15:0] count_value_reg,
   input wire logic [15:0] cycle_length_reg,
   input wire logic [15:0] cycle_length_shadow,
   input wire logic cycle_shadow_valid,
   input wire logic [47:0] match_values,
   input wire logic [2:0] match_flag,
   input wire logic [2:0] wave_out,
   input wire logic [2:0] waveform_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Steps are predicted only for undivided ticks, so slower prescales are left to the bench.
   wire logic run1 = enable && prescale_select == 3'h0 && !event_count_enable && !count_write
      && !cycle_write;
   wire logic at_top = count_value_reg == cycle_length_reg;
   wire logic up_nrm = run1 && !count_down && wave_mode_select == 2'h0;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_count_write_wins: assert property (
      count_write |=> count_value_reg == $past(write_data)) else $error("count write lost");
   chk_hold_when_off: assert property (
      !enable && !count_write |=> $stable(count_value_reg)) else $error("count moved while off");
   chk_up_step_wrap: assert property (
      up_nrm |=> count_value_reg == ($past(at_top) ? 16'h0000 : $past(count_value_reg) + 16'h0001))
      else $error("up count step wrong");
   chk_down_reload: assert property (
      run1 && count_down && wave_mode_select == 2'h0 && count_value_reg == 16'h0000
      && !cycle_shadow_valid |=> at_top) else $error("down reload wrong");
   chk_load_copy: assert property (
      up_nrm && at_top && cycle_shadow_valid && !cycle_shadow_write
      |=> cycle_length_reg == $past(cycle_length_shadow) && !cycle_shadow_valid)
      else $error("shadow not loaded");
   chk_no_early_copy: assert property (
      !cycle_write && !at_top && count_value_reg != 16'h0000
      && count_value_reg != match_values[15:0] |=> $stable(cycle_length_reg))
      else $error("cycle length changed early");
   chk_match_flag_set: assert property (
      run1 && count_value_reg == match_values[31:16] |=> match_flag[1])
      else $error("match flag not set");
   chk_toggle_match: assert property (
      run1 && !count_down && wave_mode_select == 2'h1 && count_value_reg == match_values[15:0]
      |=> count_value_reg == 16'h0000 && $changed(wave_out[0])) else $error("toggle wrong");
   chk_slope_set_top: assert property (
      run1 && wave_mode_select == 2'h3 && at_top |=> wave_out[2] && count_value_reg == 16'h0000)
      else $error("slope set wrong");
   chk_pin_override: assert property (
      waveform_pin[1] == ((wave_mode_select[0] && !event_count_enable && channel_output_enable[1])
      ? wave_out[1] : port_out[1])) else $error("pin override wrong");
   cover property (wave_mode_select == 2'h1 && $changed(wave_out[0]));
   cover property (up_nrm && at_top && cycle_shadow_valid);
   cover property (event_count_enable && enable && $changed(count_value_reg));
endmodule : wtu_checker
`default_nettype wire

// file: wave_timer_unit_bench.sv
// Self-checking bench for the wave timer unit.
`default_nettype none
module wave_timer_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, reset, enable, count_down, event_count_enable, event_in, wrap_flag_clear, pw;
   logic cycle_shadow_valid, wrap_flag;
   logic [1:0] wave_mode_select;
   logic [2:0] prescale_select, channel_output_enable, match_flag_clear, port_out;
   logic [2:0] match_shadow_valid, match_flag, wave_out, waveform_pin;
   logic [8:0] wsel;
   logic [15:0] write_data, count_value_reg, cycle_length_reg, cycle_length_shadow, m;
   logic [47:0] match_values, match_shadows;
   wire logic count_write, cycle_write, cycle_shadow_write;
   wire logic [2:0] match_write, match_shadow_write;
   int error_cnt = 0, n_tests = 0, cyc = 0, tg, hi[3];
   int seed = 32'h56b8;
   assign {match_shadow_write, match_write, cycle_shadow_write, cycle_write, count_write} = wsel;
   wave_timer_unit dut_u (.ref_clk, .reset, .enable, .prescale_select, .count_down,
      .wave_mode_select, .channel_output_enable, .event_count_enable, .event_in, .write_data,
      .count_write, .cycle_write, .cycle_shadow_write, .match_write, .match_shadow_write,
      .match_flag_clear, .wrap_flag_clear, .port_out, .count_value_reg, .cycle_length_reg,
      .cycle_length_shadow, .cycle_shadow_valid, .match_values, .match_shadows,
      .match_shadow_valid, .wrap_flag, .match_flag, .wave_out, .waveform_pin);
   // Write strobes stay up until the next wait, so back-to-back writes never glitch.
   task automatic tick(input int n);
      if (wsel !== 9'h000) begin
         wsel = 9'h000;
      end
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   // Index k: 0 count, 1 cycle, 2 cycle shadow, 3..5 match, 6..8 match shadow.
   task automatic wr(input int k, input logic [15:0] d);
      write_data = d;
      wsel = 9'(1 << k);
      @(posedge ref_clk);
      #1;
   endtask : wr
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   function automatic int div_of(input int i);
      return (i < 5) ? (1 << i) : (16 << (2 * (i - 4)));
   endfunction : div_of
   initial begin
      ref_clk = 0;
      forever #50 ref_clk = ~ref_clk;
   end
   // The longest test, the divide sweep, needs under 3000 cycles.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 12000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   initial begin
      {reset, enable, count_down, event_count_enable, event_in, wrap_flag_clear} = 6'h20;
      {prescale_select, channel_output_enable, match_flag_clear, wave_mode_select} = 11'h000;
      write_data = 16'h0000;
      port_out = 3'h5;
      tick(4);
      reset = 0;
      chk(count_value_reg, 16'h0000);
      chk(cycle_length_reg, 16'hFFFF);
      chk(match_values[15:0], 16'h0000);
      $display("test reset finished");
      wr(1, 16'h0004);
      enable = 1;
      tick(7);
      chk(count_value_reg, 16'h0002);
      count_down = 1;
      tick(3);
      chk(count_value_reg, 16'h0004);
      repeat (6) begin
         m = 16'($random(seed));
         wr(0, m);
         chk(count_value_reg, m);
      end
      enable = 0;
      count_down = 0;
      wr(0, 16'h000A);
      enable = 1;
      wr(1, 16'h0005);
      tick(2);
      chk(count_value_reg, 16'h000D);
      $display("test counting finished");
      for (int i = 0; i < 8; i++) begin
         enable = 0;
         prescale_select = 3'(i);
         wr(0, 16'h0000);
         enable = 1;
         tick(2 * div_of(i));
         chk(count_value_reg, 16'h0002);
      end
      $display("test prescale finished");
      enable = 0;
      prescale_select = 3'h0;
      wr(0, 16'h0000);
      wr(2, 16'h0003);
      wr(8, 16'h0002);
      chk(cycle_length_shadow, 16'h0003);
      chk(match_shadows[47:32], 16'h0002);
      chk(16'({cycle_shadow_valid, match_shadow_valid}), 16'h000C);
      enable = 1;
      tick(5);
      chk(cycle_length_reg, 16'h0005);
      tick(1);
      chk(cycle_length_reg, 16'h0003);
      chk(match_values[47:32], 16'h0002);
      chk(16'({cycle_shadow_valid, match_shadow_valid}), 16'h0000);
      enable = 0;
      for (int n = 0; n < 3; n++) wr(3 + n, 16'(n));
      match_flag_clear = 3'h7;
      wrap_flag_clear = 1;
      tick(1);
      match_flag_clear = 3'h0;
      wrap_flag_clear = 0;
      chk(16'({wrap_flag, match_flag}), 16'h0000);
      enable = 1;
      tick(5);
      chk(16'({wrap_flag, match_flag}), 16'h000F);
      $display("test buffering finished");
      // Cycle length three gives the smallest two-bit slope.
      wave_mode_select = 2'h3;
      channel_output_enable = 3'h2;
      tick(8);
      hi = '{0, 0, 0};
      repeat (40) begin
         tick(1);
         for (int n = 0; n < 3; n++) hi[n] += int'(wave_out[n]);
      end
      for (int n = 0; n < 3; n++) chk(16'(hi[n]), 16'(10 * (n + 1)));
      chk(16'(waveform_pin), 16'({port_out[2], wave_out[1], port_out[0]}));
      $display("test slope finished");
      wave_mode_select = 2'h1;
      for (int k = 0; k < 4; k++) begin
         m = (k == 0) ? 16'h0000 : 16'($random(seed) & 7);
         enable = 0;
         wr(3, m);
         wr(0, 16'h0000);
         enable = 1;
         tick(2);
         tg = 0;
         repeat (8 * (m + 1)) begin
            pw = wave_out[0];
            tick(1);
            if (wave_out[0] !== pw) tg++;
         end
         chk(16'(tg), 16'h0008);
      end
      $display("test toggle finished");
      wave_mode_select = 2'h3;
      enable = 0;
      wr(0, 16'h0000);
      event_count_enable = 1;
      channel_output_enable = 3'h7;
      enable = 1;
      repeat (3) begin
         event_in = 1;
         tick(3);
         event_in = 0;
         tick(3);
      end
      tick(4);
      chk(count_value_reg, 16'h0003);
      chk(16'(waveform_pin), 16'(port_out));
      $display("test events finished");
      report_and_stop;
   end
endmodule : wave_timer_unit_bench
bind wave_timer_unit wtu_checker chk_u (.ref_clk, .reset, .enable, .prescale_select,
   .count_down, .wave_mode_select, .channel_output_enable, .event_count_enable, .write_data,
   .count_write, .cycle_write, .cycle_shadow_write, .port_out, .count_value_reg,
   .cycle_length_reg, .cycle_length_shadow, .cycle_shadow_valid, .match_values, .match_flag,
   .wave_out, .waveform_pin);
`default_nettype wire
